//--- design/spinv_params.svh
// Constants for the serial pin inversion and pin-function block.
// Assumes inclusion by bare name from the package and the modules that need it.
`ifndef SPINV_PARAMS_SVH
`define SPINV_PARAMS_SVH

// Address of the inversion and pin-function control register
`define SPINV_CTRL_ADDR 16'hff91
// Value after reset: reserved bits high, everything else off
`define SPINV_CTRL_RESET 8'hc0
// Bits that always read as one and ignore writes
`define SPINV_CTRL_RSVD 2'h3
// Value returned for a read of any other address
`define SPINV_UNMAPPED_DATA 8'h00

// Field positions inside the control register
`define SPINV_RX1_INVERT_BIT 0
`define SPINV_TX1_INVERT_BIT 1
`define SPINV_RX2_INVERT_BIT 2
`define SPINV_TX2_INVERT_BIT 3
`define SPINV_TX1_SELECT_BIT 4
`define SPINV_TX2_SELECT_BIT 5
// Width of the writable part of the register
`define SPINV_CTRL_RW_BITS 6

// Pin synchroniser depth in flip-flops
`define SPINV_SYNC_STAGES 2

`endif

//--- design/spinv_pkg.sv
// Types shared by the serial pin inversion block.
// Assumes the constants header sits beside this file.
`include "spinv_params.svh"

package spinv_pkg;

    // Register bus address and data
    typedef logic [15:0] spinv_addr_t;
    typedef logic [7:0] spinv_data_t;
    // Writable part of the control register
    typedef logic [`SPINV_CTRL_RW_BITS-1:0] spinv_ctrl_t;

endpackage : spinv_pkg

//--- design/spinv_lane.sv
// One serial channel's pin lane: receive inversion and transmit pin multiplexer.
// Assumes the serial channel and port logic run on CLK; pin levels are asynchronous.
`timescale 1ns/1ns
`include "spinv_params.svh"

module spinv_lane
    import spinv_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic rx_invert,
    input wire logic tx_invert,
    input wire logic tx_select,
    input wire logic rx_pin,
    output logic rx_data,
    input wire logic tx_data,
    input wire logic port_dout,
    input wire logic port_dir,
    output logic port_din,
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_n
);

    // Synchroniser chains; only the last stage is read by logic
    logic [`SPINV_SYNC_STAGES-1:0] rx_sync_r;
    logic [`SPINV_SYNC_STAGES-1:0] pin_sync_r;
    logic rx_clean;
    logic tx_shaped;

    // Receive pin and transmit pin readback both pass two flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_sync_r <= '0;
            pin_sync_r <= '0;
        end else begin
            rx_sync_r <= {rx_sync_r[0], rx_pin};
            pin_sync_r <= {pin_sync_r[0], tx_pin_in};
        end
    end

    // Inversion is a bare XOR so a new setting acts at once, glitches included
    assign rx_clean = rx_sync_r[`SPINV_SYNC_STAGES-1];
    assign rx_data = rx_clean ^ rx_invert;
    assign tx_shaped = tx_data ^ tx_invert;

    // Pin multiplexer after the inverter: port use or serial transmit use
    assign tx_pin_out = tx_select ? tx_shaped : port_dout;
    assign tx_pin_oe_n = tx_select ? 1'b0 : ~port_dir;
    // Port logic always sees the pin level, whatever the pin is used for
    assign port_din = pin_sync_r[`SPINV_SYNC_STAGES-1];

endmodule : spinv_lane

//--- design/spinv_top.sv
// Serial pin inversion and transmit pin-function control for two serial channels.
// Assumes the serial channels and port logic share CLK; pins are asynchronous to it.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`include "spinv_params.svh"

module spinv_top
    import spinv_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [15:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // First serial channel side
    input wire logic SERIAL1_TX_DATA,
    output logic SERIAL1_RX_DATA,
    // Second serial channel side
    input wire logic SERIAL2_TX_DATA,
    output logic SERIAL2_RX_DATA,
    // Port logic side of the shared transmit pins
    input wire logic PORT3_BIT5_IO_DOUT,
    input wire logic PORT3_BIT5_IO_DIR,
    output logic PORT3_BIT5_IO_DIN,
    input wire logic PORT4_BIT2_IO_DOUT,
    input wire logic PORT4_BIT2_IO_DIR,
    output logic PORT4_BIT2_IO_DIN,
    // Receive pins
    input wire logic SERIAL1_RECEIVE_PIN,
    input wire logic SERIAL2_RECEIVE_PIN,
    // Transmit pins, shared with port use
    input wire logic SERIAL1_TRANSMIT_PIN_IN,
    output logic SERIAL1_TRANSMIT_PIN_OUT,
    output logic SERIAL1_TRANSMIT_PIN_OE_N,
    input wire logic SERIAL2_TRANSMIT_PIN_IN,
    output logic SERIAL2_TRANSMIT_PIN_OUT,
    output logic SERIAL2_TRANSMIT_PIN_OE_N
);

    localparam int NUM_CH = 2;

    // Only the writable bits are stored; the reserved pair is constant
    spinv_ctrl_t ctrl_r;
    spinv_ctrl_t ctrl_nxt;
    spinv_data_t rdata_r;
    spinv_data_t rdata_nxt;
    spinv_data_t ctrl_view;
    logic addr_hit;
    logic ctrl_wr;
    logic ctrl_rd;

    // Per-channel bundles for the generate loop; index 0 is the first channel
    logic [NUM_CH-1:0] rx_inv;
    logic [NUM_CH-1:0] tx_inv;
    logic [NUM_CH-1:0] tx_sel;
    logic [NUM_CH-1:0] rx_pin;
    logic [NUM_CH-1:0] rx_data;
    logic [NUM_CH-1:0] tx_data;
    logic [NUM_CH-1:0] port_dout;
    logic [NUM_CH-1:0] port_dir;
    logic [NUM_CH-1:0] port_din;
    logic [NUM_CH-1:0] pin_in;
    logic [NUM_CH-1:0] pin_out;
    logic [NUM_CH-1:0] pin_oe_n;

    // Address decode
    assign addr_hit = (REG_ADDR == `SPINV_CTRL_ADDR);
    assign ctrl_wr = REG_WR && addr_hit;
    assign ctrl_rd = REG_RD && addr_hit;

    // Reserved bits are forced high on every read and never stored
    assign ctrl_view = {`SPINV_CTRL_RSVD, ctrl_r};
    assign ctrl_nxt = ctrl_wr ? REG_WDATA[`SPINV_CTRL_RW_BITS-1:0] : ctrl_r;
    // Unmapped reads answer zero rather than leaving the bus undefined
    assign rdata_nxt = ctrl_rd ? ctrl_view :
                       (REG_RD ? `SPINV_UNMAPPED_DATA : rdata_r);

    // Control register; the write lands at the edge and acts the cycle after
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r <= spinv_ctrl_t'(`SPINV_CTRL_RESET);
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read data register, valid in the cycle after the read strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= `SPINV_UNMAPPED_DATA;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

    // Field extraction; the fields feed the lanes directly, no retiming
    assign rx_inv = {ctrl_r[`SPINV_RX2_INVERT_BIT], ctrl_r[`SPINV_RX1_INVERT_BIT]};
    assign tx_inv = {ctrl_r[`SPINV_TX2_INVERT_BIT], ctrl_r[`SPINV_TX1_INVERT_BIT]};
    assign tx_sel = {ctrl_r[`SPINV_TX2_SELECT_BIT], ctrl_r[`SPINV_TX1_SELECT_BIT]};

    // Gather the separate ports into channel vectors
    assign rx_pin = {SERIAL2_RECEIVE_PIN, SERIAL1_RECEIVE_PIN};
    assign tx_data = {SERIAL2_TX_DATA, SERIAL1_TX_DATA};
    assign port_dout = {PORT4_BIT2_IO_DOUT, PORT3_BIT5_IO_DOUT};
    assign port_dir = {PORT4_BIT2_IO_DIR, PORT3_BIT5_IO_DIR};
    assign pin_in = {SERIAL2_TRANSMIT_PIN_IN, SERIAL1_TRANSMIT_PIN_IN};

    // One lane per channel
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_lane
            spinv_lane u_lane (
                .clk(CLK),
                .reset_n(RESET_N),
                .rx_invert(rx_inv[ch]),
                .tx_invert(tx_inv[ch]),
                .tx_select(tx_sel[ch]),
                .rx_pin(rx_pin[ch]),
                .rx_data(rx_data[ch]),
                .tx_data(tx_data[ch]),
                .port_dout(port_dout[ch]),
                .port_dir(port_dir[ch]),
                .port_din(port_din[ch]),
                .tx_pin_in(pin_in[ch]),
                .tx_pin_out(pin_out[ch]),
                .tx_pin_oe_n(pin_oe_n[ch])
            );
        end
    endgenerate

    // Spread the lane results back onto the named ports
    assign SERIAL1_RX_DATA = rx_data[0];
    assign SERIAL2_RX_DATA = rx_data[1];
    assign PORT3_BIT5_IO_DIN = port_din[0];
    assign PORT4_BIT2_IO_DIN = port_din[1];
    assign SERIAL1_TRANSMIT_PIN_OUT = pin_out[0];
    assign SERIAL1_TRANSMIT_PIN_OE_N = pin_oe_n[0];
    assign SERIAL2_TRANSMIT_PIN_OUT = pin_out[1];
    assign SERIAL2_TRANSMIT_PIN_OE_N = pin_oe_n[1];

    // Cycles since reset release, saturating; lets checks skip synchroniser fill
    logic [1:0] alive_cnt_r;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            alive_cnt_r <= 2'h0;
        end else if (alive_cnt_r != 2'h3) begin
            alive_cnt_r <= alive_cnt_r + 2'h1;
        end
    end

    // Reset state is visible on the first read after release
    reset_value_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h0) |-> (ctrl_view == `SPINV_CTRL_RESET))
        else $error("control register not at reset value after release");

    // Reserved bits read one and survive writes of zero
    rsvd_read_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (ctrl_rd && !$past(ctrl_wr)) ##1 1'b1 |-> (REG_RDATA[7:6] == 2'h3))
        else $error("reserved bits did not read as one");

    // A write updates only the writable bits, seen by the next read
    write_read_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        ctrl_wr ##1 (ctrl_rd && !ctrl_wr) |=>
            (REG_RDATA == {2'h3, $past(REG_WDATA[5:0], 2)}))
        else $error("read back differs from last write");

    // Unmapped reads answer zero
    unmapped_read_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (REG_RD && !addr_hit) |=> (REG_RDATA == `SPINV_UNMAPPED_DATA))
        else $error("unmapped read did not return zero");

    // Port use of the shared pins follows the port logic
    tx2_port_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !ctrl_r[`SPINV_TX2_SELECT_BIT] |->
            (SERIAL2_TRANSMIT_PIN_OUT == PORT4_BIT2_IO_DOUT) &&
            (SERIAL2_TRANSMIT_PIN_OE_N == !PORT4_BIT2_IO_DIR))
        else $error("second transmit pin not in port use");

    tx1_port_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !ctrl_r[`SPINV_TX1_SELECT_BIT] |->
            (SERIAL1_TRANSMIT_PIN_OUT == PORT3_BIT5_IO_DOUT) &&
            (SERIAL1_TRANSMIT_PIN_OE_N == !PORT3_BIT5_IO_DIR))
        else $error("first transmit pin not in port use");

    // Serial use drives the pin with the possibly inverted data
    tx2_invert_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        ctrl_r[`SPINV_TX2_SELECT_BIT] |->
            !SERIAL2_TRANSMIT_PIN_OE_N &&
            (SERIAL2_TRANSMIT_PIN_OUT == (SERIAL2_TX_DATA ^ ctrl_r[`SPINV_TX2_INVERT_BIT])))
        else $error("second transmit pin data wrong");

    tx1_invert_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        ctrl_r[`SPINV_TX1_SELECT_BIT] |->
            !SERIAL1_TRANSMIT_PIN_OE_N &&
            (SERIAL1_TRANSMIT_PIN_OUT == (SERIAL1_TX_DATA ^ ctrl_r[`SPINV_TX1_INVERT_BIT])))
        else $error("first transmit pin data wrong");

    // Receive data is the pin two edges back, inverted by the current bit
    rx2_invert_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h3) |->
            (SERIAL2_RX_DATA == ($past(SERIAL2_RECEIVE_PIN, 2) ^ ctrl_r[`SPINV_RX2_INVERT_BIT])))
        else $error("second receive data wrong");

    rx1_invert_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h3) |->
            (SERIAL1_RX_DATA == ($past(SERIAL1_RECEIVE_PIN, 2) ^ ctrl_r[`SPINV_RX1_INVERT_BIT])))
        else $error("first receive data wrong");

    // A write that flips transmit inversion flips the pin in the very next cycle
    sequence flip_tx1_s;
        ctrl_wr && ctrl_r[`SPINV_TX1_SELECT_BIT] && REG_WDATA[`SPINV_TX1_SELECT_BIT] &&
            (REG_WDATA[`SPINV_TX1_INVERT_BIT] != ctrl_r[`SPINV_TX1_INVERT_BIT]);
    endsequence

    sequence flipped_tx1_s;
        (SERIAL1_TRANSMIT_PIN_OUT == (SERIAL1_TX_DATA ^ $past(REG_WDATA[`SPINV_TX1_INVERT_BIT])));
    endsequence

    invert_immediate_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        flip_tx1_s |=> flipped_tx1_s)
        else $error("inversion change did not act at once");

    // The same for a receive inversion flip, with no resynchronisation delay
    rx_flip_now_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (ctrl_wr && (alive_cnt_r == 2'h3) && $stable(SERIAL1_RECEIVE_PIN) &&
            (REG_WDATA[`SPINV_RX1_INVERT_BIT] != ctrl_r[`SPINV_RX1_INVERT_BIT])) |=>
            (SERIAL1_RX_DATA != $past(SERIAL1_RX_DATA)) ||
            ($past(SERIAL1_RECEIVE_PIN, 2) != $past(SERIAL1_RECEIVE_PIN, 3)))
        else $error("receive inversion change delayed");

    // Second receive lane: a pin edge in flight may mask the flip, nothing else may
    rx2_flip_now_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (ctrl_wr && (alive_cnt_r == 2'h3) &&
            (REG_WDATA[`SPINV_RX2_INVERT_BIT] != ctrl_r[`SPINV_RX2_INVERT_BIT])) |=>
            (SERIAL2_RX_DATA != $past(SERIAL2_RX_DATA)) ||
            ($past(SERIAL2_RECEIVE_PIN, 2) != $past(SERIAL2_RECEIVE_PIN, 3)))
        else $error("second receive inversion change delayed");

    // Second transmit lane flips at once as well
    sequence flip_tx2_s;
        ctrl_wr && ctrl_r[`SPINV_TX2_SELECT_BIT] && REG_WDATA[`SPINV_TX2_SELECT_BIT] &&
            (REG_WDATA[`SPINV_TX2_INVERT_BIT] != ctrl_r[`SPINV_TX2_INVERT_BIT]);
    endsequence

    sequence flipped_tx2_s;
        (SERIAL2_TRANSMIT_PIN_OUT == (SERIAL2_TX_DATA ^ $past(REG_WDATA[`SPINV_TX2_INVERT_BIT])));
    endsequence

    tx2_flip_now_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        flip_tx2_s |=> flipped_tx2_s)
        else $error("second inversion change did not act at once");

    // Read data hold between reads, so a slow reader still finds its answer
    rdata_hold_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");

    // Writes to other addresses must not disturb the control bits
    unmapped_write_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (REG_WR && !addr_hit) |=> $stable(ctrl_r))
        else $error("unmapped write changed the control register");

    // Straight after release both shared pins are back in port use
    reset_port_use_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h0) |->
            (SERIAL1_TRANSMIT_PIN_OUT == PORT3_BIT5_IO_DOUT) &&
            (SERIAL2_TRANSMIT_PIN_OUT == PORT4_BIT2_IO_DOUT))
        else $error("transmit pins not in port use after reset");

    // Port logic reads the pad two edges late, whatever the pin is used for
    tx1_readback_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h3) |-> (PORT3_BIT5_IO_DIN == $past(SERIAL1_TRANSMIT_PIN_IN, 2)))
        else $error("first port readback wrong");

    tx2_readback_a: assert property (
        @(posedge CLK) disable iff (!RESET_N)
        (alive_cnt_r == 2'h3) |-> (PORT4_BIT2_IO_DIN == $past(SERIAL2_TRANSMIT_PIN_IN, 2)))
        else $error("second port readback wrong");

endmodule : spinv_top

//--- bench/spinv_far_end.sv
// Far side of the pin lanes: two serial transmitters and the transmit pads.
// Assumes the transmitters run on the same clock; pads carry a pull-up when released.
`timescale 1ns/1ns

module spinv_far_end (
    input wire logic te1,
    input wire logic bit1,
    input wire logic te2,
    input wire logic bit2,
    input wire logic tx1_out,
    input wire logic tx1_oe_n,
    input wire logic tx2_out,
    input wire logic tx2_oe_n,
    output logic ser1_tx,
    output logic ser2_tx,
    output logic tx1_pad,
    output logic tx2_pad
);
    // A channel without transmit enable idles at mark level
    assign ser1_tx = te1 ? bit1 : 1'b1;
    assign ser2_tx = te2 ? bit2 : 1'b1;
    // Pull-up wins when the lane releases the pad
    assign tx1_pad = tx1_oe_n ? 1'b1 : tx1_out;
    assign tx2_pad = tx2_oe_n ? 1'b1 : tx2_out;
endmodule : spinv_far_end

//--- bench/serial_pin_data_inversion_tb.sv
// Self-checking bench for the serial pin inversion block with random pin traffic.
// Assumes the far-end model beside it and the design package and header.
`timescale 1ns/1ns
`include "spinv_params.svh"

module serial_pin_data_inversion_tb;
    import spinv_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    spinv_addr_t reg_addr = 16'h0000;
    spinv_data_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    spinv_data_t reg_rdata;
    logic s1_tx, s1_rx, s2_tx, s2_rx, p3_din, p4_din, tx1_pad, tx2_pad;
    logic tx1_out, tx1_oe_n, tx2_out, tx2_oe_n;
    logic te1 = 1'b0, te2 = 1'b0, bit1 = 1'b0, bit2 = 1'b0, rx1_line = 1'b1, rx2_line = 1'b1;
    logic p3_dout = 1'b0, p3_dir = 1'b0, p4_dout = 1'b0, p4_dir = 1'b0;
    spinv_data_t ctrl = `SPINV_CTRL_RESET;
    spinv_data_t w;
    int n_errors = 0;
    int compares = 0;

    // Ten nanosecond clock
    always #5 clk = ~clk;

    spinv_top dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .SERIAL1_TX_DATA(s1_tx), .SERIAL1_RX_DATA(s1_rx), .SERIAL2_TX_DATA(s2_tx), .SERIAL2_RX_DATA(s2_rx),
        .PORT3_BIT5_IO_DOUT(p3_dout), .PORT3_BIT5_IO_DIR(p3_dir), .PORT3_BIT5_IO_DIN(p3_din),
        .PORT4_BIT2_IO_DOUT(p4_dout), .PORT4_BIT2_IO_DIR(p4_dir), .PORT4_BIT2_IO_DIN(p4_din),
        .SERIAL1_RECEIVE_PIN(rx1_line), .SERIAL2_RECEIVE_PIN(rx2_line),
        .SERIAL1_TRANSMIT_PIN_IN(tx1_pad), .SERIAL1_TRANSMIT_PIN_OUT(tx1_out),
        .SERIAL1_TRANSMIT_PIN_OE_N(tx1_oe_n), .SERIAL2_TRANSMIT_PIN_IN(tx2_pad),
        .SERIAL2_TRANSMIT_PIN_OUT(tx2_out), .SERIAL2_TRANSMIT_PIN_OE_N(tx2_oe_n));

    spinv_far_end far (.te1(te1), .bit1(bit1), .te2(te2), .bit2(bit2), .tx1_out(tx1_out),
        .tx1_oe_n(tx1_oe_n), .tx2_out(tx2_out), .tx2_oe_n(tx2_oe_n), .ser1_tx(s1_tx),
        .ser2_tx(s2_tx), .tx1_pad(tx1_pad), .tx2_pad(tx2_pad));

    // Expected pin drive: serial data through inversion, else port data untouched
    function automatic logic exp_out(logic sel, logic inv, logic tx, logic dout);
        return sel ? (tx ^ inv) : dout;
    endfunction : exp_out

    function automatic logic exp_oe_n(logic sel, logic dir);
        return sel ? 1'b0 : ~dir;
    endfunction : exp_oe_n

    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Caller sits just after a rising edge; each task returns just after one
    task automatic reg_write(input spinv_addr_t a, input spinv_data_t d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data appear in the cycle after the strobe and hold until the next read; look at mid-cycle
    task automatic reg_read(input spinv_addr_t a, input spinv_data_t e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(reg_rdata, e);
        @(posedge clk);
    endtask : reg_read

    task automatic check_lanes();
        check(tx1_out, exp_out(ctrl[4], ctrl[1], s1_tx, p3_dout));
        check(tx1_oe_n, exp_oe_n(ctrl[4], p3_dir));
        check(tx2_out, exp_out(ctrl[5], ctrl[3], s2_tx, p4_dout));
        check(tx2_oe_n, exp_oe_n(ctrl[5], p4_dir));
        check(s1_rx, rx1_line ^ ctrl[0]);
        check(s2_rx, rx2_line ^ ctrl[2]);
    endtask : check_lanes

    // Random pin traffic, held long enough for the receive synchronisers
    task automatic drive_pins();
        logic [15:0] r;
        r = 16'($urandom);
        {bit1, bit2, p3_dout, p3_dir, p4_dout, p4_dir, rx1_line, rx2_line} <= r[7:0];
        te1 <= ctrl[4] & r[8];
        te2 <= ctrl[5] & r[9];
        repeat (3) @(posedge clk);
        @(negedge clk);
        check_lanes();
        check(p3_din, exp_oe_n(ctrl[4], p3_dir) ? 1'b1 : exp_out(ctrl[4], ctrl[1], s1_tx, p3_dout));
        check(p4_din, exp_oe_n(ctrl[5], p4_dir) ? 1'b1 : exp_out(ctrl[5], ctrl[3], s2_tx, p4_dout));
        @(posedge clk);
    endtask : drive_pins

    // Hang guard
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(62));
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        reg_read(`SPINV_CTRL_ADDR, `SPINV_CTRL_RESET);
        reg_read(16'hff90, `SPINV_UNMAPPED_DATA);
        drive_pins();
        for (int i = 0; i < 40; i++) begin
            w = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : (i == 2) ? 8'h2a : (i == 3) ? 8'h15 : 8'($urandom);
            // Channels are idled around a control change so no false edge is sent
            te1 <= 1'b0;
            te2 <= 1'b0;
            reg_write(`SPINV_CTRL_ADDR, w);
            ctrl = {2'b11, w[5:0]};
            @(negedge clk);
            check_lanes();
            @(posedge clk);
            reg_write(16'hff90, ~w);
            reg_read(`SPINV_CTRL_ADDR, ctrl);
            // Write then read with no gap; channels are still idle here
            w = 8'($urandom);
            reg_write(`SPINV_CTRL_ADDR, w);
            ctrl = {2'b11, w[5:0]};
            reg_read(`SPINV_CTRL_ADDR, ctrl);
            repeat (3) drive_pins();
        end
        // Reset in mid-run restores port mode and no inversion
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        ctrl = `SPINV_CTRL_RESET;
        reg_read(`SPINV_CTRL_ADDR, `SPINV_CTRL_RESET);
        drive_pins();
        print_verdict();
    end
endmodule : serial_pin_data_inversion_tb
